/* File: srbc_pkg.sv */
// Package with constants and types for the system reset and droop control block.
`default_nettype none
package srbc_pkg;
  localparam int unsigned CLK_HZ            = 40000000;
  localparam int unsigned WAKE_CLOCKS       = 256;
  localparam int unsigned WAKE_W            = 9;
  localparam logic [WAKE_W-1:0] WAKE_LAST   = WAKE_W'(WAKE_CLOCKS - 1);
  localparam logic [31:0] RESET_FETCH_ADDR  = 32'h0000_0000;
  localparam logic [31:0] LOCK_WORD         = 32'h8765_4321;
  localparam logic [11:0] LOCK_WORD_ADDR    = 12'h1FC;
  localparam logic [31:0] VECTOR_BASE_ADDR  = 32'h0000_0000;
  localparam int unsigned RC_OSC_KHZ        = 4000;
  localparam int unsigned DROOP_WARN_MV     = 2950;
  localparam int unsigned DROOP_RESET_MV    = 2650;
  localparam int unsigned DROOP_HOLD_MV     = 1000;
  localparam logic [1:0] CLKSRC_RC          = 2'h0;
  localparam logic       MAP_BOOT_ROM       = 1'b0;
  localparam logic       MAP_SRAM           = 1'b1;
  localparam logic       DEBUG_LOCK_RST     = 1'b0;

  typedef enum logic [2:0] {
    SRBC_HOLD = 3'b001,
    SRBC_WAKE = 3'b010,
    SRBC_RUN  = 3'b100
  } srbc_state_t;

  typedef struct packed {
    logic pin_reset_n;
    logic watchdog;
    logic power_on;
    logic droop_reset;
  } srbc_src_t;

  typedef struct packed {
    logic osc_running;
    logic flash_init_done;
  } srbc_ready_t;
endpackage
`default_nettype wire

/* File: srbc_supply_model.sv */
// Model of the supply supervisors, oscillator and flash start-up around the block.
`timescale 1ns/10ps
`default_nettype none
module srbc_supply_model #(
  parameter int unsigned READY_CLOCKS = 40
) (
  input  wire logic             clk,
  input  wire logic             chip_reset,
  input  wire logic             flash_stall,
  input  wire logic [11:0]      supply_mv,
  output logic                  droop_warn_cmp,
  output logic                  droop_reset,
  output logic                  power_on,
  output srbc_pkg::srbc_ready_t ready
);
  import srbc_pkg::*;
  logic [7:0] count_reg;
  // Comparators on the supply level.
  assign droop_warn_cmp = supply_mv < 12'(DROOP_WARN_MV);
  assign droop_reset    = supply_mv < 12'(DROOP_RESET_MV);
  assign power_on       = supply_mv < 12'(DROOP_HOLD_MV);
  // Oscillator and flash come up a while after chip reset drops.
  assign ready.osc_running     = count_reg > 8'h07;
  assign ready.flash_init_done = count_reg == 8'(READY_CLOCKS) && !flash_stall;
  always_ff @(posedge clk) begin
    if (chip_reset) count_reg <= 8'h00;
    else if (count_reg != 8'(READY_CLOCKS)) count_reg <= count_reg + 8'h01;
  end
endmodule // srbc_supply_model
`default_nettype wire

/* File: srbc_sync2.sv */
// Two-stage synchroniser for one level.
`timescale 1ns/10ps
`default_nettype none
module srbc_sync2 (
  input  wire logic clk,
  input  wire logic d,
  output var  logic q
);
  logic meta_reg;
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q        <= meta_reg;
  end
endmodule // srbc_sync2
`default_nettype wire

/* File: srbc_top.sv */
// System reset sequencing, supply droop handling, code lock and vector map.
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module srbc_top
  import srbc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire srbc_pkg::srbc_src_t   reset_src,
  input  wire srbc_pkg::srbc_ready_t ready_in,
  input  wire logic              droop_warn_cmp,
  input  wire logic              droop_irq_enable,
  input  wire logic              boot_checksum_ok,
  input  wire logic [31:0]       boot_lock_data,
  input  wire logic [11:0]       boot_lock_addr,
  input  wire logic              boot_check_strobe,
  input  wire logic              isp_full_erase_done,
  input  wire logic              map_select,
  input  wire logic              clk_select_write,
  input  wire logic [1:0]        clk_select_data,
  input  wire logic [3:0]        ext_irq,
  input  wire logic [3:0]        ext_wake_enable,
  input  wire logic              power_down,
  output logic                   chip_reset,
  output logic                   core_reset,
  output logic [31:0]            fetch_addr,
  output logic                   droop_irq,
  output logic                   droop_status,
  output logic                   flash_write_block,
  output logic                   debug_disable,
  output logic                   vector_from_sram,
  output logic [1:0]             clk_source,
  output logic                   wake_up
);
  import srbc_pkg::*;

  // ---------------------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------------------
  // Requests are combinational so they act without waiting for a clock.
  wire reset_request = ~reset_src.pin_reset_n | reset_src.watchdog
                     | reset_src.power_on | reset_src.droop_reset;
  assign chip_reset = reset_request | srst;
  assign flash_write_block = reset_src.droop_reset | core_reset;

  // ---------------------------------------------------------------------------
  // Wake-up sequencer
  // ---------------------------------------------------------------------------
  srbc_state_t        state_reg, state_next;
  logic [WAKE_W-1:0]  wake_cnt_reg, wake_cnt_next;
  wire release_ok = reset_src.pin_reset_n & ready_in.osc_running
                  & ready_in.flash_init_done & (wake_cnt_reg == WAKE_LAST);

  always_comb begin
    state_next    = state_reg;
    wake_cnt_next = wake_cnt_reg;
    unique case (state_reg)
      SRBC_HOLD: begin
        wake_cnt_next = '0;
        state_next    = SRBC_WAKE;
      end
      SRBC_WAKE: begin
        if (wake_cnt_reg != WAKE_LAST) begin
          wake_cnt_next = wake_cnt_reg + WAKE_W'(1);
        end
        if (release_ok) begin
          state_next = SRBC_RUN;
        end
      end
      SRBC_RUN: state_next = SRBC_RUN;
      default: state_next = SRBC_HOLD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (chip_reset) begin
      state_reg    <= SRBC_HOLD;
      wake_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  // Release happens on a clock edge, so every register held by core_reset leaves reset together.
  assign core_reset = chip_reset | (state_reg != SRBC_RUN);
  assign fetch_addr = RESET_FETCH_ADDR;

  // Cycles since chip reset dropped; only the release check reads it.
  logic [WAKE_W-1:0] quiet_cnt_reg;
  always_ff @(posedge clk) begin
    if (chip_reset) begin
      quiet_cnt_reg <= '0;
    end else if (quiet_cnt_reg != WAKE_W'(WAKE_CLOCKS)) begin
      quiet_cnt_reg <= quiet_cnt_reg + WAKE_W'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // Supply droop interrupt
  // ---------------------------------------------------------------------------
  logic droop_sync;
  srbc_sync2 u_droop_sync (
    .clk (clk),
    .d   (droop_warn_cmp),
    .q   (droop_sync)
  );

  logic droop_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      droop_reg <= 1'b0;
    end else begin
      droop_reg <= droop_sync;
    end
  end
  assign droop_status = droop_reg;
  assign droop_irq    = droop_reg & droop_irq_enable;

  // ---------------------------------------------------------------------------
  // Code security
  // ---------------------------------------------------------------------------
  logic lock_reg;
  wire lock_hit = boot_check_strobe & boot_checksum_ok & (boot_lock_data == LOCK_WORD)
                & (boot_lock_addr == LOCK_WORD_ADDR);
  always_ff @(posedge clk) begin
    if (isp_full_erase_done) begin
      lock_reg <= 1'b0;
    end else if (lock_hit) begin
      lock_reg <= 1'b1;
    end
  end
  // The lock is retained across reset; only an erase clears it.
  assign debug_disable = lock_reg;

  // ---------------------------------------------------------------------------
  // Vector map, clock source and wake-up
  // ---------------------------------------------------------------------------
  logic map_reg;
  logic [1:0] clk_src_reg;
  logic wake_reg;
  always_ff @(posedge clk) begin
    if (core_reset) begin
      map_reg     <= MAP_BOOT_ROM;
      clk_src_reg <= CLKSRC_RC;
      wake_reg    <= 1'b0;
    end else begin
      map_reg <= map_select;
      if (clk_select_write) begin
        clk_src_reg <= clk_select_data;
      end
      wake_reg <= power_down & |(ext_irq & ext_wake_enable);
    end
  end
  assign vector_from_sram = map_reg;
  assign clk_source       = clk_src_reg;
  assign wake_up          = wake_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_src_reset: assert property (@(posedge clk) reset_request |-> chip_reset)
    else $error("Reset source did not assert chip reset.");
  chk_hold_wake: assert property (@(posedge clk) chip_reset |=> state_reg == SRBC_HOLD)
    else $error("Reset did not restart wake-up timer.");
  chk_release_cond: assert property (@(posedge clk) disable iff (chip_reset)
      (state_reg == SRBC_WAKE) && !release_ok |=> core_reset)
    else $error("Core reset released early.");
  chk_release_sync: assert property (@(posedge clk) disable iff (chip_reset)
      $fell(core_reset) |-> $past(release_ok))
    else $error("Release not tied to clock edge.");
  chk_droop_irq: assert property (@(posedge clk) disable iff (srst)
      droop_irq |-> droop_status && droop_irq_enable)
    else $error("Droop irq without enable.");
  chk_droop_lat: assert property (@(posedge clk) disable iff (srst)
      $rose(droop_warn_cmp) ##1 droop_warn_cmp ##1 droop_warn_cmp |=> droop_status)
    else $error("Droop status late.");
  chk_flash_block: assert property (@(posedge clk) reset_src.droop_reset |-> flash_write_block)
    else $error("Flash not blocked on droop reset.");
  chk_lock_set: assert property (@(posedge clk) lock_hit && !isp_full_erase_done
      |=> debug_disable)
    else $error("Debug not locked.");
  chk_lock_clear: assert property (@(posedge clk) isp_full_erase_done |=> !debug_disable)
    else $error("Erase did not unlock debug.");
  chk_clk_rc: assert property (@(posedge clk) core_reset |=> clk_source == CLKSRC_RC)
    else $error("Clock source not RC after reset.");
  chk_release_wait: assert property (@(posedge clk) disable iff (chip_reset)
      $fell(core_reset) |-> quiet_cnt_reg == WAKE_W'(WAKE_CLOCKS))
    else $error("Core reset released before the wake-up count.");
  chk_release_ready: assert property (@(posedge clk) disable iff (chip_reset)
      $fell(core_reset) |-> $past(reset_src.pin_reset_n && ready_in.osc_running
      && ready_in.flash_init_done))
    else $error("Core reset released while a release condition was missing.");
  chk_fetch_zero: assert property (@(posedge clk)
      !core_reset |-> fetch_addr == RESET_FETCH_ADDR)
    else $error("Fetch address not zero out of reset.");
  chk_map_boot: assert property (@(posedge clk) core_reset |=> !vector_from_sram)
    else $error("Vectors not mapped to boot ROM after reset.");
  chk_wake_event: assert property (@(posedge clk) disable iff (core_reset)
      power_down && |(ext_irq & ext_wake_enable) |=> wake_up)
    else $error("Enabled external interrupt did not wake the core.");
  chk_droop_clear: assert property (@(posedge clk) disable iff (srst)
      !droop_warn_cmp [*3] |=> !droop_status)
    else $error("Droop status did not clear.");
endmodule // srbc_top
`default_nettype wire

/* File: srbc_top_tb.sv */
// Self-checking bench for the system reset and droop control block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module srbc_top_tb;
  import srbc_pkg::*;
  logic clk = 1'b0, srst = 1'b1, pin_n = 1'b1, wdog = 1'b0, stall = 1'b0, en = 1'b0;
  logic ok = 1'b0, strobe = 1'b0, erase = 1'b0, map = 1'b0, csw = 1'b0, pd = 1'b0;
  logic [1:0] csd = 2'h0;
  logic [3:0] irq = 4'h0, wen = 4'h0;
  logic [11:0] mv = 12'hCE4, addr = 12'h000;
  logic [31:0] data = 32'h0;
  logic chip_reset, core_reset, d_irq, d_stat, fwb, dbg, vsram, wake, warn, supply_droop_detector, por, expv;
  logic [31:0] fetch;
  logic [1:0] csrc;
  srbc_pkg::srbc_ready_t rdy;
  integer seed = 32'h68A0, miscompares = 0, checks_done = 0, n, k;
  always #12.5 clk = ~clk;
  srbc_supply_model srbc_supply_model_i (.clk(clk), .chip_reset(chip_reset),
    .flash_stall(stall), .supply_mv(mv), .droop_warn_cmp(warn), .droop_reset(supply_droop_detector),
    .power_on(por), .ready(rdy));
  srbc_top srbc_top_i (.clk(clk), .srst(srst), .reset_src({pin_n, wdog, por, supply_droop_detector}),
    .ready_in(rdy), .droop_warn_cmp(warn), .droop_irq_enable(en), .boot_checksum_ok(ok),
    .boot_lock_data(data), .boot_lock_addr(addr), .boot_check_strobe(strobe),
    .isp_full_erase_done(erase), .map_select(map), .clk_select_write(csw),
    .clk_select_data(csd), .ext_irq(irq), .ext_wake_enable(wen), .power_down(pd),
    .chip_reset(chip_reset), .core_reset(core_reset), .fetch_addr(fetch),
    .droop_irq(d_irq), .droop_status(d_stat), .flash_write_block(fwb),
    .debug_disable(dbg), .vector_from_sram(vsram), .clk_source(csrc), .wake_up(wake));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic complete_run;
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wait_run(input int lim, input bit must);
    n = 0;
    while (core_reset !== 1'b0 && n < lim) begin tick(1); n++; end
    if (must && n == lim) begin miscompares++; complete_run(); end
  endtask
  initial begin repeat (90000) @(posedge clk); miscompares++; complete_run(); end
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0; erase <= 1'b1; csw <= 1'b1; csd <= 2'h1;
    tick(1);
    `CHK("chip_reset", 1'b0, chip_reset)
    erase <= 1'b0; csw <= 1'b0;
    wait_run(400, 1);
    `CHK("wake_len", 1'b1, n >= 250 && n <= 262)
    `CHK("fetch", RESET_FETCH_ADDR, fetch)
    `CHK("clk_src", CLKSRC_RC, csrc)
    `CHK("status", 1'b0, d_stat)
    for (k = 0; k < 5; k++) begin
      @(posedge clk) begin csw <= 1'b1; csd <= 2'h2; end
      @(posedge clk) csw <= 1'b0;
      @(posedge clk) case (k)
        0: pin_n <= 1'b0; 1: wdog <= 1'b1; 2: mv <= 12'h1F4; 3: mv <= 12'hA28;
        default: begin wdog <= 1'b1; stall <= 1'b1; end
      endcase
      #1;
      `CHK("chip_reset", 1'b1, chip_reset)
      if (k == 3) `CHK("flash_block", 1'b1, fwb)
      tick(1 + ($unsigned($random(seed)) % 8));
      pin_n <= 1'b1; wdog <= 1'b0; mv <= 12'hCE4;
      wait_run(400, k < 4);
      if (k == 4) begin
        `CHK("held", 1'b1, core_reset)
        stall <= 1'b0;
        wait_run(20, 1);
      end
      `CHK("wake_len", 1'b1, k == 4 || (n >= 250 && n <= 262))
      `CHK("clk_src", CLKSRC_RC, csrc)
    end
    for (k = 0; k < 6; k++) begin
      en <= 1'($random(seed)); mv <= 12'hB54;
      tick(4);
      `CHK("status", 1'b1, d_stat)
      `CHK("irq", en, d_irq)
      mv <= 12'hCE4;
      tick(4);
      `CHK("irq_off", 1'b0, d_irq | d_stat)
    end
    for (k = 0; k < 8; k++) begin
      ok <= k == 0 || $random(seed); strobe <= 1'b1; erase <= k == 2;
      data <= (k < 3) ? LOCK_WORD : $random(seed);
      addr <= (k != 1) ? LOCK_WORD_ADDR : 12'h1F8;
      tick(1);
      strobe <= 1'b0; erase <= 1'b0;
      expv = k != 2 && ok && data == LOCK_WORD && addr == LOCK_WORD_ADDR;
      tick(2);
      `CHK("debug_off", expv, dbg)
      erase <= 1'b1;
      tick(1);
      erase <= 1'b0;
      tick(2);
      `CHK("debug_back", 1'b0, dbg)
      map <= 1'($random(seed)); irq <= 4'($random(seed));
      wen <= 4'($random(seed)); pd <= 1'($random(seed));
      tick(3);
      `CHK("map", map, vsram)
      `CHK("wake", pd && |(irq & wen), wake)
    end
    complete_run();
  end
endmodule // srbc_top_tb
`default_nettype wire
